// File: core/cvp_pkg.sv
// constants, types and layouts for the config_variable programming interpreter
// Contract
// - Accept writes in direct, register, paged service modes and main-line programming.
// - Main-line programming matches locomotive address; writes stored, reads never answered.
// - Service-track writes execute whatever the addressed locomotive.
// - Bit 0 is the least significant, bit 7 the most significant.
// - Two-digit format runs a dedicated dialogue and returns no read values.
// - Two-digit number 80 is taken as zero.
// - Short mode: numbers and values below 80; brief periodic headlight flashes.
// - Short mode: confirmed number latched as target, two very quick flashes.
// - Confirmed value written to target, one-second light; more writes may follow.
// - Short mode left by selecting 80 or by power off then on.
// - Value 07 to variable 07 in short mode enters long mode, slow flashing.
// - Long mode reaches every variable and value 0 to 255 in two-part entries.
// - Long mode takes hundreds-tens of number, then long-short pattern awaiting units.
// - After number units confirmed, await value with long-short-short pattern.
// - Value hundreds-tens shows long-short-short-short; units write, one-second light, continue.
// - Long mode left only by power off then on.
// - Helper 96 holds indirect target hundreds, helper 97 units and tens.
// - Writing helper 99 copies its value at once into the indirect target.
// - After the indirect copy, helpers 96, 97 and 99 return to zero.
package cvp_pkg;

   localparam int unsigned CV_NUM_W        = 10;
   localparam int unsigned MM_NUM_W        = 7;

   // helper variables of the indirect path
   localparam logic [9:0]  CV_HELPER_HI    = 10'h060;
   localparam logic [9:0]  CV_HELPER_LO    = 10'h061;
   localparam logic [9:0]  CV_HELPER_TRIG  = 10'h063;
   localparam logic [7:0]  HELPER_RESET    = 8'h00;

   // two-digit dialogue codes
   localparam logic [6:0]  MM_ZERO_CODE    = 7'h50;
   localparam logic [6:0]  MM_LONG_KEY     = 7'h07;
   localparam logic [13:0] DEC_BASE        = 14'h000A;
   localparam logic [15:0] HUND_BASE       = 16'h0064;

   // register / paged service-mode map
   localparam logic [9:0]  REG_CFG_IDX     = 10'h005;
   localparam logic [9:0]  CV_CFG          = 10'h01D;
   localparam logic [9:0]  REG_PAGE_IDX    = 10'h006;
   localparam logic [9:0]  REG_LAST_IDX    = 10'h008;
   localparam logic [9:0]  PAGE_SIZE_IDX   = 10'h004;
   localparam logic [7:0]  PAGE_RESET      = 8'h01;

   // light timing
   localparam int unsigned CLK_PERIOD_NS   = 50;
   localparam int unsigned SLOT_NS         = 100_000_000;
   localparam int unsigned SLOT_CYCLES     = SLOT_NS / CLK_PERIOD_NS;
   localparam int unsigned ACK_NS          = 1_000_000_000;
   localparam logic [3:0]  ACK_SLOTS       = 4'(ACK_NS / SLOT_NS);
   localparam logic [3:0]  QUICK_SLOTS     = 4'h4;

   // light patterns, one bit per slot, bit 0 first
   localparam logic [15:0] PAT_OFF         = 16'h0000;
   localparam logic [15:0] PAT_SHORT       = 16'h0001;
   localparam logic [15:0] PAT_SLOW        = 16'h00FF;
   localparam logic [15:0] PAT_L_S         = 16'h0017;
   localparam logic [15:0] PAT_L_S_S       = 16'h0057;
   localparam logic [15:0] PAT_L_S_S_S     = 16'h0157;

   typedef enum logic [1:0] {
      CVP_DIRECT   = 2'h0,
      CVP_REGISTER = 2'h1,
      CVP_PAGED    = 2'h2,
      CVP_MAIN     = 2'h3
   } cvp_mode_t;

   typedef struct packed {
      cvp_mode_t   mode;
      logic        write;
      logic [7:0]  loco;
      logic [9:0]  index;
      logic [7:0]  value;
   } cvp_cmd_t;

   typedef struct packed {
      logic [6:0]  num;
      logic        dir;
   } cvp_mm_t;

   typedef struct packed {
      logic [9:0]  num;
      logic [7:0]  data;
   } cvp_cv_wr_t;

   typedef enum logic [6:0] {
      ST_RUN         = 7'h01,
      ST_SHORT_CV    = 7'h02,
      ST_SHORT_VAL   = 7'h04,
      ST_LONG_CV_HI  = 7'h08,
      ST_LONG_CV_LO  = 7'h10,
      ST_LONG_VAL_HI = 7'h20,
      ST_LONG_VAL_LO = 7'h40
   } cvp_state_t;

   typedef enum logic [1:0] {
      OVL_NONE  = 2'h0,
      OVL_QUICK = 2'h1,
      OVL_ACK   = 2'h2
   } cvp_ovl_t;

endpackage

// File: core/cvp_interp.sv
// config_variable programming interpreter: service, main-line, two-digit and indirect paths
`timescale 1ns/1ps

module cvp_interp
   import cvp_pkg::*;
#(
   parameter int unsigned SLOT_CYC = SLOT_CYCLES
)(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        track_power_i,
   input  wire logic [7:0]  my_addr_i,
   input  wire logic        cmd_valid_i,
   input  wire cvp_cmd_t    cmd_i,
   input  wire logic        mm_valid_i,
   input  wire cvp_mm_t     mm_i,
   output logic             cv_we_o,
   output cvp_cv_wr_t       cv_wr_o,
   output logic             rd_req_o,
   output logic [9:0]       rd_num_o,
   output logic             rd_done_o,
   output logic [7:0]       rd_data_o,
   output logic             prog_light_o,
   output logic             motor_hold_o,
   output logic             drive_enable_o,
   output logic             prog_active_o,
   output logic             long_mode_o
);

   if (SLOT_CYC < 2) begin : g_bad_slot
      $error("cvp_interp: SLOT_CYC must be at least 2");
   end

   localparam int unsigned SLOT_W = $clog2(SLOT_CYC + 1);

   function automatic logic [6:0] mm_value(input logic [6:0] a);
      return (a == MM_ZERO_CODE) ? 7'h00 : a;
   endfunction

   function automatic logic [9:0] two_part(input logic [6:0] hi, input logic [6:0] lo);
      logic [13:0] s;
      s = 14'(hi) * DEC_BASE + 14'(lo);
      return s[9:0];
   endfunction

   function automatic logic [15:0] hundreds(input logic [7:0] h, input logic [7:0] l);
      return 16'(h) * HUND_BASE + 16'(l);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // reset release and track power synchroniser

   logic rst_meta_reg;
   logic rst_n;

   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_reg <= 1'b0;
         rst_n        <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n        <= rst_meta_reg;
      end
   end

   logic pwr_meta_reg;
   logic pwr_sync_reg;
   logic pwr_prev_reg;

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pwr_meta_reg <= 1'b0;
         pwr_sync_reg <= 1'b0;
         pwr_prev_reg <= 1'b0;
      end else begin
         pwr_meta_reg <= track_power_i;
         pwr_sync_reg <= pwr_meta_reg;
         pwr_prev_reg <= pwr_sync_reg;
      end
   end

   wire pwr_rise = pwr_sync_reg & ~pwr_prev_reg;
   wire pwr_lost = ~pwr_sync_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // standard service / main-line command decode

   cvp_state_t st_reg;
   cvp_state_t st_next;
   logic [7:0] page_reg;
   logic [7:0] h_hi_reg;
   logic [7:0] h_lo_reg;

   wire dlg_active = (st_reg != ST_RUN);

   wire        is_main    = (cmd_i.mode == CVP_MAIN);
   wire        loco_match = (cmd_i.loco == my_addr_i);
   wire [9:0]  idx        = cmd_i.index;
   wire        reg_small  = (idx != 10'h000) && (idx <= REG_LAST_IDX);
   wire        page_idx   = (idx >= 10'h001) && (idx <= PAGE_SIZE_IDX);
   wire [9:0]  page_base  = {page_reg - 8'h01, 2'h0};

   // register mode: 1..4,7,8 straight, 5 is the configuration byte, 6 the page register
   wire        reg_page   = (cmd_i.mode == CVP_REGISTER) && (idx == REG_PAGE_IDX);
   wire [9:0]  reg_num    = (idx == REG_CFG_IDX) ? CV_CFG : idx;

   logic [9:0] std_num;
   logic       std_hit;

   always_comb begin
      std_num = idx;
      std_hit = 1'b0;
      case (cmd_i.mode)
         CVP_DIRECT:   std_hit = 1'b1;
         CVP_MAIN:     std_hit = 1'b1;
         CVP_REGISTER: begin
            std_num = reg_num;
            std_hit = reg_small && !reg_page;
         end
         CVP_PAGED:    begin
            std_num = page_base + idx;
            std_hit = page_idx;
         end
         default:      std_hit = 1'b0;
      endcase
   end

   // service track ignores the address; the main line must match it
   wire std_ok   = cmd_valid_i && !dlg_active && (is_main ? loco_match : 1'b1);
   wire std_we   = std_ok && cmd_i.write && std_hit;
   wire page_we  = std_ok && cmd_i.write && reg_page;
   wire std_rd   = std_ok && !cmd_i.write && !is_main && (std_hit || reg_page);

   ////////////////////////////////////////////////////////////////////////////////
   // two-digit dialogue

   logic       fresh_reg;
   logic       dir_prev_reg;
   logic [6:0] num_reg;
   logic [6:0] part_reg;
   logic [6:0] part_next;
   logic [9:0] sel_reg;
   logic [9:0] sel_next;
   logic       dlg_we;
   logic [9:0] dlg_num;
   logic [7:0] dlg_val;
   cvp_ovl_t   ovl_req;

   wire [6:0] mm_num   = mm_value(mm_i.num);
   wire       confirm  = mm_valid_i && mm_i.dir && !dir_prev_reg;
   // own address or the unknown-address code, direction held right after power-on
   wire       addr_hit = (mm_i.num == MM_ZERO_CODE) || ({1'b0, mm_i.num} == my_addr_i);
   wire       enter    = mm_valid_i && fresh_reg && mm_i.dir && addr_hit;
   wire [9:0] long_val = two_part(part_reg, num_reg);

   always_comb begin
      st_next   = st_reg;
      part_next = part_reg;
      sel_next  = sel_reg;
      dlg_we    = 1'b0;
      dlg_num   = sel_reg;
      dlg_val   = {1'b0, num_reg};
      ovl_req   = OVL_NONE;
      case (st_reg)
         ST_RUN: begin
            if (enter) begin
               st_next = ST_SHORT_CV;
            end
         end
         ST_SHORT_CV: begin
            if (confirm) begin
               if (num_reg == 7'h00) begin
                  st_next = ST_RUN;
               end else begin
                  sel_next = {3'h0, num_reg};
                  ovl_req  = OVL_QUICK;
                  st_next  = ST_SHORT_VAL;
               end
            end
         end
         ST_SHORT_VAL: begin
            if (confirm) begin
               if (sel_reg == {3'h0, MM_LONG_KEY} && num_reg == MM_LONG_KEY) begin
                  st_next = ST_LONG_CV_HI;
               end else begin
                  dlg_we  = 1'b1;
                  ovl_req = OVL_ACK;
                  st_next = ST_SHORT_CV;
               end
            end
         end
         ST_LONG_CV_HI: begin
            if (confirm) begin
               part_next = num_reg;
               st_next   = ST_LONG_CV_LO;
            end
         end
         ST_LONG_CV_LO: begin
            if (confirm) begin
               sel_next = two_part(part_reg, num_reg);
               st_next  = ST_LONG_VAL_HI;
            end
         end
         ST_LONG_VAL_HI: begin
            if (confirm) begin
               part_next = num_reg;
               st_next   = ST_LONG_VAL_LO;
            end
         end
         ST_LONG_VAL_LO: begin
            if (confirm) begin
               // results above 255 cannot be stored and are dropped
               dlg_we  = (long_val[9:8] == 2'h0);
               dlg_val = long_val[7:0];
               ovl_req = OVL_ACK;
               st_next = ST_LONG_CV_HI;
            end
         end
         default: st_next = ST_RUN;
      endcase
      if (pwr_lost) begin
         st_next = ST_RUN;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_reg       <= ST_RUN;
         sel_reg      <= 10'h000;
         part_reg     <= 7'h00;
         num_reg      <= 7'h00;
         dir_prev_reg <= 1'b0;
         fresh_reg    <= 1'b0;
      end else begin
         st_reg    <= st_next;
         sel_reg   <= sel_next;
         part_reg  <= part_next;
         if (mm_valid_i) begin
            dir_prev_reg <= mm_i.dir;
            if (!mm_i.dir) begin
               num_reg <= mm_num;
            end
         end
         // only the first packet after power-on may open the dialogue
         if (pwr_rise) begin
            fresh_reg <= 1'b1;
         end else if (mm_valid_i || pwr_lost) begin
            fresh_reg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // write path with indirect helpers

   wire       any_we  = std_we || dlg_we;
   wire [9:0] wr_num  = dlg_we ? dlg_num : std_num;
   wire [7:0] wr_val  = dlg_we ? dlg_val : cmd_i.value;
   wire       wr_hi   = any_we && (wr_num == CV_HELPER_HI);
   wire       wr_lo   = any_we && (wr_num == CV_HELPER_LO);
   wire       wr_trig = any_we && (wr_num == CV_HELPER_TRIG);
   wire       wr_std  = any_we && !wr_hi && !wr_lo && !wr_trig;

   wire [15:0] ind_full = hundreds(h_hi_reg, h_lo_reg);
   wire        ind_ok   = (ind_full[15:10] == 6'h00);

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         h_hi_reg <= HELPER_RESET;
         h_lo_reg <= HELPER_RESET;
         page_reg <= PAGE_RESET;
         cv_we_o  <= 1'b0;
         cv_wr_o  <= '0;
      end else begin
         cv_we_o <= 1'b0;
         if (wr_hi) begin
            h_hi_reg <= wr_val;
         end
         if (wr_lo) begin
            h_lo_reg <= wr_val;
         end
         if (page_we) begin
            page_reg <= cmd_i.value;
         end
         if (wr_trig) begin
            cv_we_o  <= ind_ok;
            // an out-of-range target is dropped; the last write stays on the port
            if (ind_ok) begin
               cv_wr_o <= '{num: ind_full[9:0], data: wr_val};
            end
            h_hi_reg <= HELPER_RESET;
            h_lo_reg <= HELPER_RESET;
         end else if (wr_std) begin
            cv_we_o <= 1'b1;
            cv_wr_o <= '{num: wr_num, data: wr_val};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read path: helpers and page answered here, others forwarded

   wire rd_local = std_rd && (reg_page || std_num == CV_HELPER_HI
                   || std_num == CV_HELPER_LO || std_num == CV_HELPER_TRIG);

   logic [7:0] local_data;

   always_comb begin
      local_data = HELPER_RESET;
      if (reg_page) begin
         local_data = page_reg;
      end else if (std_num == CV_HELPER_HI) begin
         local_data = h_hi_reg;
      end else if (std_num == CV_HELPER_LO) begin
         local_data = h_lo_reg;
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         rd_req_o  <= 1'b0;
         rd_num_o  <= 10'h000;
         rd_done_o <= 1'b0;
         rd_data_o <= 8'h00;
      end else begin
         rd_req_o  <= std_rd && !rd_local;
         rd_done_o <= rd_local;
         if (std_rd) begin
            rd_num_o  <= std_num;
            rd_data_o <= local_data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // light feedback: slot ticks, state pattern and overlays

   logic [SLOT_W-1:0] slot_cnt_reg;
   logic [3:0]        step_reg;
   logic [3:0]        ovl_cnt_reg;
   cvp_ovl_t          ovl_kind_reg;
   logic [15:0]       pat;

   wire slot_tick = (slot_cnt_reg == SLOT_W'(SLOT_CYC - 1));

   always_comb begin
      case (st_reg)
         ST_SHORT_CV:    pat = PAT_SHORT;
         ST_SHORT_VAL:   pat = PAT_SHORT;
         ST_LONG_CV_HI:  pat = PAT_SLOW;
         ST_LONG_CV_LO:  pat = PAT_L_S;
         ST_LONG_VAL_HI: pat = PAT_L_S_S;
         ST_LONG_VAL_LO: pat = PAT_L_S_S_S;
         default:        pat = PAT_OFF;
      endcase
   end

   wire ovl_on    = (ovl_kind_reg == OVL_ACK) || ovl_cnt_reg[0];
   wire light_nxt = (ovl_cnt_reg != 4'h0) ? ovl_on : pat[step_reg];

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         slot_cnt_reg <= '0;
         step_reg     <= 4'h0;
         ovl_cnt_reg  <= 4'h0;
         ovl_kind_reg <= OVL_NONE;
         prog_light_o <= 1'b0;
      end else begin
         // restart the slot on an overlay so its first slot is never cut short
         slot_cnt_reg <= (slot_tick || ovl_req != OVL_NONE) ? '0
                         : slot_cnt_reg + SLOT_W'(1);
         if (slot_tick) begin
            step_reg <= step_reg + 4'h1;
         end
         if (ovl_req != OVL_NONE) begin
            ovl_kind_reg <= ovl_req;
            ovl_cnt_reg  <= (ovl_req == OVL_ACK) ? ACK_SLOTS : QUICK_SLOTS;
         end else if (pwr_lost) begin
            ovl_cnt_reg <= 4'h0;
         end else if (slot_tick && ovl_cnt_reg != 4'h0) begin
            ovl_cnt_reg <= ovl_cnt_reg - 4'h1;
         end
         prog_light_o <= light_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // status outputs

   always_ff @(posedge ref_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         motor_hold_o   <= 1'b0;
         drive_enable_o <= 1'b1;
         prog_active_o  <= 1'b0;
         long_mode_o    <= 1'b0;
      end else begin
         motor_hold_o   <= (st_next != ST_RUN);
         drive_enable_o <= (st_next == ST_RUN);
         prog_active_o  <= (st_next != ST_RUN);
         long_mode_o    <= (st_next != ST_RUN) && (st_next != ST_SHORT_CV)
                           && (st_next != ST_SHORT_VAL);
      end
   end

endmodule // cvp_interp

// File: bench/cvp_interp_chk.sv
// port checker for the programming interpreter
`timescale 1ns/1ps

module cvp_interp_chk
   import cvp_pkg::*;
#(
   parameter int unsigned SLOT_CYC = SLOT_CYCLES
)(
   input  wire logic        ref_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        track_power_i,
   input  wire logic [7:0]  my_addr_i,
   input  wire logic        cmd_valid_i,
   input  wire cvp_cmd_t    cmd_i,
   input  wire logic        mm_valid_i,
   input  wire logic        cv_we_o,
   input  wire cvp_cv_wr_t  cv_wr_o,
   input  wire logic        rd_req_o,
   input  wire logic        rd_done_o,
   input  wire logic        motor_hold_o,
   input  wire logic        drive_enable_o,
   input  wire logic        prog_active_o,
   input  wire logic        long_mode_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   // plain command, no dialogue packet in the same cycle
   wire fresh = cmd_valid_i && !prog_active_o && !mm_valid_i;
   wire plain = cmd_i.write && (cmd_i.index < CV_HELPER_HI);
   wire own   = cmd_i.loco == my_addr_i;

   a_direct_write_map: assert property (
      fresh && cmd_i.mode == CVP_DIRECT && plain
      |=> cv_we_o && cv_wr_o == {$past(cmd_i.index), $past(cmd_i.value)})
      else $error("direct write not passed through");
   a_main_own_write: assert property (
      fresh && cmd_i.mode == CVP_MAIN && plain && own
      |=> cv_we_o && cv_wr_o.num == $past(cmd_i.index))
      else $error("main-line write to own address lost");
   a_main_foreign_loco: assert property (
      fresh && cmd_i.mode == CVP_MAIN && !own |=> !cv_we_o && !rd_req_o && !rd_done_o)
      else $error("main-line command for other loco executed");
   a_main_no_read: assert property (
      fresh && cmd_i.mode == CVP_MAIN && !cmd_i.write |=> !rd_req_o && !rd_done_o)
      else $error("main-line read answered");
   a_register_cfg_map: assert property (
      fresh && cmd_i.mode == CVP_REGISTER && cmd_i.write && cmd_i.index == REG_CFG_IDX
      |=> cv_we_o && cv_wr_o.num == CV_CFG)
      else $error("register 5 not mapped to variable 29");
   a_dialogue_holds: assert property (
      prog_active_o |-> motor_hold_o && !drive_enable_o)
      else $error("motor not held in dialogue");
   a_dialogue_deaf: assert property (
      prog_active_o && cmd_valid_i && !mm_valid_i |=> !cv_we_o && !rd_req_o)
      else $error("command taken during dialogue");
   a_long_in_dialogue: assert property (
      long_mode_o |-> prog_active_o)
      else $error("long mode outside dialogue");
   a_power_loss_exit: assert property (
      !track_power_i [*6] |-> !prog_active_o && !long_mode_o)
      else $error("dialogue survives power loss");
   a_wr_holds: assert property (
      !cv_we_o |-> $stable(cv_wr_o))
      else $error("write data moved without a write");
endmodule // cvp_interp_chk

bind cvp_interp cvp_interp_chk #(.SLOT_CYC(SLOT_CYC)) cvp_interp_chk_i (
   .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .track_power_i(track_power_i),
   .my_addr_i(my_addr_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
   .mm_valid_i(mm_valid_i), .cv_we_o(cv_we_o), .cv_wr_o(cv_wr_o), .rd_req_o(rd_req_o),
   .rd_done_o(rd_done_o), .motor_hold_o(motor_hold_o), .drive_enable_o(drive_enable_o),
   .prog_active_o(prog_active_o), .long_mode_o(long_mode_o));

// File: bench/cvp_station.sv
// command station model: track power, standard commands, two-digit packets
`timescale 1ns/1ps

module cvp_station
   import cvp_pkg::*;
(
   input  wire logic ref_clk_i,
   output logic      track_power_o,
   output logic      cmd_valid_o,
   output cvp_cmd_t  cmd_o,
   output logic      mm_valid_o,
   output cvp_mm_t   mm_o
);
   initial begin
      {track_power_o, cmd_valid_o, cmd_o, mm_valid_o, mm_o} = '0;
   end

   task automatic send_cmd(input cvp_mode_t m, input logic w, input logic [7:0] l,
                           input logic [9:0] n, input logic [7:0] v);
      @(posedge ref_clk_i);
      #1;
      cmd_o = '{m, w, l, n, v};
      cmd_valid_o = 1'b1;
      @(posedge ref_clk_i);
      #1;
      cmd_valid_o = 1'b0;
      cmd_o = ~cmd_o; // released data must not look valid
   endtask

   task automatic send_mm(input logic [6:0] n, input logic d);
      @(posedge ref_clk_i);
      #1;
      mm_o = '{n, d};
      mm_valid_o = 1'b1;
      @(posedge ref_clk_i);
      #1;
      mm_valid_o = 1'b0;
      mm_o = ~mm_o;
   endtask

   // power off, back on with direction held, then the given address (own, 80 or another)
   task automatic enter(input logic [6:0] addr);
      track_power_o = 1'b0;
      repeat (8) @(posedge ref_clk_i);
      #1;
      track_power_o = 1'b1;
      repeat (3) @(posedge ref_clk_i);
      send_mm(addr, 1'b1);
   endtask
endmodule // cvp_station

// File: bench/cvp_interp_tb.sv
// self-checking bench for the programming interpreter
`timescale 1ns/1ps

module cvp_interp_tb;
   import cvp_pkg::*;
   localparam int unsigned SLOT = 8;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [7:0]  my_addr = 8'h03;
   logic        pw, cv, mv, we, rq, rd, lt, hold, drv, act, lng;
   cvp_cmd_t    cmd;
   cvp_mm_t     mm;
   cvp_cv_wr_t  wr;
   logic [9:0]  rd_num;
   logic [31:0] num_errors = 0;
   logic [31:0] samples_checked = 0;
   logic [31:0] cycles = 0;
   cvp_cv_wr_t  expq[$];

   always #25 ref_clk = ~ref_clk;

   cvp_station cvp_station_i (.ref_clk_i(ref_clk), .track_power_o(pw), .cmd_valid_o(cv),
      .cmd_o(cmd), .mm_valid_o(mv), .mm_o(mm));
   cvp_interp #(.SLOT_CYC(SLOT)) cvp_interp_i (.ref_clk_i(ref_clk), .rst_n_i(rst_n),
      .track_power_i(pw), .my_addr_i(my_addr), .cmd_valid_i(cv), .cmd_i(cmd),
      .mm_valid_i(mv), .mm_i(mm), .cv_we_o(we), .cv_wr_o(wr), .rd_req_o(rq),
      .rd_num_o(rd_num), .rd_done_o(rd), .rd_data_o(), .prog_light_o(lt),
      .motor_hold_o(hold), .drive_enable_o(drv), .prog_active_o(act), .long_mode_o(lng));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("checks=%0d errors=%0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic w(input logic [9:0] n, input logic [7:0] d);
      expq.push_back('{n, d});
   endtask

   // number then direction-change confirm
   task automatic pair(input logic [6:0] n);
      cvp_station_i.send_mm(n, 1'b0);
      cvp_station_i.send_mm(n, 1'b1);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // every write pulse consumes the oldest expectation
   always @(posedge ref_clk) begin
      #2;
      if (we === 1'b1) begin
         if (expq.size() > 0) check(wr, expq.pop_front());
         else check(32'h1, 32'h0);
      end
   end

   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors++;
         finish_test;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] r;
      void'($urandom(32'h75a1));
      r = 8'($urandom());
      wait_cyc(2);
      rst_n = 1'b1;
      wait_cyc(3);
      w(10'h005, r);
      cvp_station_i.send_cmd(CVP_DIRECT, 1'b1, 8'h7A, 10'h005, r);
      w(10'h01F, 8'h07);
      cvp_station_i.send_cmd(CVP_MAIN, 1'b1, my_addr, 10'h01F, 8'h07);
      cvp_station_i.send_cmd(CVP_MAIN, 1'b1, 8'h04, 10'h01F, 8'h09);
      cvp_station_i.send_cmd(CVP_MAIN, 1'b0, my_addr, 10'h01F, 8'h00);
      check(rq, 1'b0);
      cvp_station_i.send_cmd(CVP_DIRECT, 1'b0, 8'h00, 10'h008, 8'h00);
      check({rq, rd_num}, {1'b1, 10'h008});
      w(CV_CFG, ~r);
      cvp_station_i.send_cmd(CVP_REGISTER, 1'b1, 8'h00, REG_CFG_IDX, ~r);
      w(10'h002, 8'h22);
      cvp_station_i.send_cmd(CVP_PAGED, 1'b1, 8'h00, 10'h002, 8'h22);
      cvp_station_i.send_cmd(CVP_REGISTER, 1'b1, 8'h00, REG_PAGE_IDX, 8'h02);
      w(10'h005, 8'h11);
      cvp_station_i.send_cmd(CVP_PAGED, 1'b1, 8'h00, 10'h001, 8'h11);
      cvp_station_i.send_cmd(CVP_DIRECT, 1'b1, 8'h00, CV_HELPER_HI, 8'd3);
      cvp_station_i.send_cmd(CVP_DIRECT, 1'b1, 8'h00, CV_HELPER_LO, 8'd17);
      w(10'd317, 8'd120);
      cvp_station_i.send_cmd(CVP_DIRECT, 1'b1, 8'h00, CV_HELPER_TRIG, 8'd120);
      w(10'd0, r);
      cvp_station_i.send_cmd(CVP_DIRECT, 1'b1, 8'h00, CV_HELPER_TRIG, r);
      $display("standard and indirect paths done");
      cvp_station_i.enter(MM_ZERO_CODE);
      wait_cyc(1);
      check({act, hold, drv}, 3'b110);
      cvp_station_i.send_cmd(CVP_DIRECT, 1'b1, 8'h00, 10'h005, 8'h01);
      pair(7'd5);
      wait_cyc(5);
      check(lt, 1'b0);
      wait_cyc(8);
      check(lt, 1'b1);
      w(10'd5, 8'd15);
      pair(7'd15);
      wait_cyc(40);
      check(lt, 1'b1);
      w(10'd3, 8'd0);
      pair(7'd3);
      pair(MM_ZERO_CODE);
      pair(MM_ZERO_CODE);
      wait_cyc(1);
      check({act, drv}, 2'b01);
      $display("short mode done");
      cvp_station_i.enter(my_addr[6:0]);
      pair(MM_LONG_KEY);
      pair(MM_LONG_KEY);
      wait_cyc(1);
      check({act, lng}, 2'b11);
      pair(7'd12);
      pair(7'd4);
      w(10'd124, 8'd135);
      pair(7'd13);
      pair(7'd5);
      pair(MM_ZERO_CODE);
      wait_cyc(2);
      check(act, 1'b1);
      cvp_station_i.enter(7'd9);
      check({act, lng}, 2'b00);
      wait_cyc(4);
      check(32'(expq.size()), 32'h0);
      $display("long mode done");
      finish_test;
   end
endmodule // cvp_interp_tb
